// >>> src/dhrs_pkg.sv
package dhrs_pkg;
  // =====================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned SPIKE_TIME_NS   = 5000;    // 5 us
  localparam int unsigned LOAD_TIME_MS    = 5;       // 5 ms
  localparam int unsigned BLANK_TIME_MS   = 120;     // 120 ms
  localparam int unsigned CMD_WAIT_MS     = 5;       // 5 ms
  localparam int unsigned SLEEP_WAIT_MS   = 120;     // 120 ms
  // least times round up, longest times round down
  localparam int unsigned SPIKE_CYCLES    = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOAD_CYCLES     = (LOAD_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYCLES    = (BLANK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CMD_WAIT_CYCLES = (CMD_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYCLES    = (SLEEP_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =====================================================
  // non-volatile settings layout
  localparam int unsigned NVM_WORDS       = 8;
  localparam int unsigned NVM_AW          = 3;
  localparam int unsigned ID_FIRST        = 0;       // three identification bytes
  localparam int unsigned CVOLT_INDEX     = 3;       // common_voltage_setting
  localparam logic [7:0]  SETTING_RESET   = 8'h00;

  typedef enum logic [2:0] {
    DHRS_RUN,
    DHRS_RESET,
    DHRS_LOAD,
    DHRS_FINISH
  } dhrs_state_type;

  typedef struct packed {
    logic hw_reset_active;
    logic display_blank;
    logic loading;
    logic cmd_ok;
    logic sleep_exit_ok;
  } dhrs_status_type;

  typedef struct packed {
    logic              rd_en;
    logic [NVM_AW-1:0] addr;
  } dhrs_nvm_req_type;
endpackage

// >>> src/dhrs_spike_filter.sv
`timescale 1ns/1ps
module dhrs_spike_filter
  import dhrs_pkg::*;
#(
  parameter int unsigned SPIKE = SPIKE_CYCLES
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic raw_n,
  output logic      filt_n,
  output logic      rise,
  output logic      fall
);
  localparam int unsigned CW = $clog2(SPIKE + 1);
  localparam logic [CW-1:0] LAST = CW'(SPIKE - 1);

  logic [CW-1:0] cnt;
  wire           differ = raw_n != filt_n;
  wire           flip   = differ && (cnt == LAST);

  // =====================================================
  // level changes only after SPIKE steady cycles
  // low and high spike rejection
  always_ff @(posedge clock) begin
    if (srst) begin
      filt_n <= 1'b1;
      cnt    <= '0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      rise   <= flip && raw_n;
      fall   <= flip && !raw_n;
      if (!differ || flip) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
      if (flip) begin
        filt_n <= raw_n;
      end
    end
  end
endmodule

// >>> src/dhrs_reset_seq.sv
`timescale 1ns/1ps
module dhrs_reset_seq
  import dhrs_pkg::*;
#(
  parameter int unsigned LOAD_LIMIT  = LOAD_CYCLES,
  parameter int unsigned BLANK_LIMIT = BLANK_CYCLES,
  parameter int unsigned CMD_WAIT    = CMD_WAIT_CYCLES,
  parameter int unsigned SLEEP_WAIT  = SLEEP_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       hw_reset_n,
  input  wire logic                       sleep_out_mode,
  input  wire logic                       nvm_rvalid,
  input  wire logic [7:0]                 nvm_rdata,
  output dhrs_nvm_req_type                nvm_req,
  output dhrs_status_type                 status,
  output logic [NVM_WORDS-1:0][7:0]       settings
);
  localparam int unsigned TW = $clog2(BLANK_LIMIT + SLEEP_WAIT + LOAD_LIMIT + 2);
  localparam logic [NVM_AW-1:0] LAST_ADDR = NVM_AW'(NVM_WORDS - 1);

  function automatic logic reached(input logic [TW-1:0] cnt, input int unsigned lim);
    return cnt >= TW'(lim);
  endfunction

  dhrs_state_type state;
  dhrs_state_type next_state;
  logic           filt_n;
  logic           rel_pulse;
  logic           start_pulse;
  logic           from_sleep_out;
  logic [TW-1:0]  blank_cnt;
  logic [TW-1:0]  since_rel;

  // =====================================================
  // spike filter
  dhrs_spike_filter #(.SPIKE(SPIKE_CYCLES)) dhrs_spike_filter_inst (
    .clock  (clock),
    .srst   (srst),
    .raw_n  (hw_reset_n),
    .filt_n (filt_n),
    .rise   (rel_pulse),
    .fall   (start_pulse)
  );

  // =====================================================
  // decode
  wire last_word  = nvm_rvalid && (nvm_req.addr == LAST_ADDR);
  // cancel ends on load and blanking
  // blanking only runs its full length when reset came in sleep-out
  wire blank_done = !from_sleep_out || reached(blank_cnt, BLANK_LIMIT - 1);
  // gives up one cycle early so the finish cycle still lands inside the limit
  wire load_late  = reached(since_rel, LOAD_LIMIT - 2);

  // a low pin during load or finish starts the reset over
  always_comb begin
    next_state = state;
    case (state)
      DHRS_RUN:    if (!filt_n) next_state = DHRS_RESET;
      DHRS_RESET:  if (rel_pulse) next_state = DHRS_LOAD;
      DHRS_LOAD: begin
        if (!filt_n) next_state = DHRS_RESET;
        else if (last_word || load_late) next_state = DHRS_FINISH;
      end
      DHRS_FINISH: begin
        if (!filt_n) next_state = DHRS_RESET;
        else if (blank_done) next_state = DHRS_RUN;
      end
      default:     next_state = DHRS_RUN;
    endcase
  end

  // =====================================================
  // sequencer state and sleep mode capture
  // mid-length pulse starts reset once filter accepts it
  always_ff @(posedge clock) begin
    if (srst) begin
      state          <= DHRS_RUN;
      from_sleep_out <= 1'b0;
    end else begin
      state <= next_state;
      if (state == DHRS_RUN && start_pulse) begin
        from_sleep_out <= sleep_out_mode;
      end
    end
  end

  // =====================================================
  // blanking and release timers
  // blanking time from reset start
  always_ff @(posedge clock) begin
    if (srst || state == DHRS_RUN) begin
      blank_cnt <= '0;
    end else if (!reached(blank_cnt, BLANK_LIMIT)) begin
      blank_cnt <= blank_cnt + TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst || !filt_n) begin
      since_rel <= '0;
    end else if (!reached(since_rel, SLEEP_WAIT)) begin
      since_rel <= since_rel + TW'(1);
    end
  end

  // =====================================================
  // settings reload
  // fetch words after every release
  always_ff @(posedge clock) begin
    if (srst) begin
      nvm_req  <= '0;
      settings <= {NVM_WORDS{SETTING_RESET}};
    end else if (state == DHRS_RESET) begin
      // first read leaves with the move into load
      nvm_req.rd_en <= next_state == DHRS_LOAD;
      nvm_req.addr  <= '0;
      settings      <= {NVM_WORDS{SETTING_RESET}};
    end else if (state == DHRS_LOAD && next_state == DHRS_LOAD) begin
      // one read outstanding: the next leaves only once a word has landed
      nvm_req.rd_en <= nvm_rvalid;
      if (nvm_rvalid) begin
        settings[nvm_req.addr] <= nvm_rdata;
        nvm_req.addr           <= nvm_req.addr + NVM_AW'(1);
      end
    end else begin
      nvm_req.rd_en <= 1'b0;
      if (state == DHRS_LOAD && nvm_rvalid) begin
        settings[nvm_req.addr] <= nvm_rdata;
      end
    end
  end

  // =====================================================
  // status outputs
  // sleep exit allowed after 120ms
  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
    end else begin
      status.hw_reset_active <= next_state == DHRS_RESET;
      status.display_blank   <= next_state != DHRS_RUN;
      status.loading         <= next_state == DHRS_LOAD;
      status.cmd_ok          <= filt_n && reached(since_rel, CMD_WAIT - 1) && next_state == DHRS_RUN;
      status.sleep_exit_ok   <= filt_n && reached(since_rel, SLEEP_WAIT - 1) && next_state == DHRS_RUN;
    end
  end

  // =====================================================
  // checks
  logic [TW-1:0] low_run;
  logic [TW-1:0] high_run;
  always_ff @(posedge clock) begin
    if (srst) begin
      low_run  <= '0;
      high_run <= '0;
    end else begin
      // run counters stop at full scale so a long level never wraps into a false alarm
      low_run  <= hw_reset_n ? '0 : low_run + TW'(!(&low_run));
      high_run <= hw_reset_n ? high_run + TW'(!(&high_run)) : '0;
    end
  end

  property p_spike_reject;
    @(posedge clock) disable iff (srst) $fell(filt_n) |-> $past(low_run) >= TW'(SPIKE_CYCLES - 1);
  endproperty
  a_spike_reject: assert property (p_spike_reject) else $error("reset accepted from short low");

  property p_long_reset;
    @(posedge clock) disable iff (srst) (low_run == TW'(SPIKE_CYCLES + 1)) |-> !filt_n;
  endproperty
  a_long_reset: assert property (p_long_reset) else $error("long low pulse not taken as reset");

  property p_glitch_hold;
    @(posedge clock) disable iff (srst) $rose(filt_n) |-> $past(high_run) >= TW'(SPIKE_CYCLES - 1);
  endproperty
  a_glitch_hold: assert property (p_glitch_hold) else $error("high glitch ended reset");

  property p_load_bound;
    @(posedge clock) disable iff (srst) state == DHRS_LOAD |-> since_rel < TW'(LOAD_LIMIT);
  endproperty
  a_load_bound: assert property (p_load_bound) else $error("settings reload too slow");

  property p_blank;
    @(posedge clock) disable iff (srst) state == DHRS_RESET |=> status.display_blank;
  endproperty
  a_blank: assert property (p_blank) else $error("display not blank in reset");

  property p_cancel_bound;
    @(posedge clock) disable iff (srst)
      (state != DHRS_RUN && filt_n) |-> since_rel < TW'(from_sleep_out ? BLANK_LIMIT : LOAD_LIMIT);
  endproperty
  a_cancel_bound: assert property (p_cancel_bound) else $error("reset cancel too long");

  property p_cmd_wait;
    @(posedge clock) disable iff (srst) status.cmd_ok |-> since_rel >= TW'(CMD_WAIT - 1);
  endproperty
  a_cmd_wait: assert property (p_cmd_wait) else $error("command allowed too early");

  property p_sleep_wait;
    @(posedge clock) disable iff (srst) status.sleep_exit_ok |-> status.cmd_ok && since_rel >= TW'(SLEEP_WAIT - 1);
  endproperty
  a_sleep_wait: assert property (p_sleep_wait) else $error("sleep exit allowed too early");

  c_reset:    cover property (@(posedge clock) disable iff (srst) state == DHRS_RESET ##1 state == DHRS_LOAD);
  c_load:     cover property (@(posedge clock) disable iff (srst) state == DHRS_LOAD && last_word);
  c_reenter:  cover property (@(posedge clock) disable iff (srst)
                (state == DHRS_LOAD || state == DHRS_FINISH) ##1 state == DHRS_RESET);
  c_abandon:  cover property (@(posedge clock) disable iff (srst) state == DHRS_LOAD && load_late);
  c_done:     cover property (@(posedge clock) disable iff (srst) $rose(status.sleep_exit_ok));
endmodule

// >>> bench/dhrs_nvm_model.sv
`timescale 1ns/1ps
// =====================================================
// settings memory behind the sequencer, with a chosen answer delay
module dhrs_nvm_model
  import dhrs_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire dhrs_nvm_req_type nvm_req,
  input  wire logic [7:0]       delay,
  output logic                  nvm_rvalid,
  output logic [7:0]            nvm_rdata
);
  logic [7:0]        count;
  logic              busy;
  logic [NVM_AW-1:0] addr;

  // data toggles while idle so a stale word is never mistaken for a fresh one
  always_ff @(posedge clock) begin
    nvm_rvalid <= 1'b0;
    if (srst) begin
      busy      <= 1'b0;
      count     <= 8'h00;
      addr      <= '0;
      nvm_rdata <= 8'h00;
    end else if (nvm_req.rd_en) begin
      busy      <= 1'b1;
      count     <= delay;
      addr      <= nvm_req.addr;
      nvm_rdata <= ~nvm_rdata;
    end else if (busy && count == 8'h00) begin
      busy       <= 1'b0;
      nvm_rvalid <= 1'b1;
      nvm_rdata  <= 8'hA0 ^ {5'h00, addr};
    end else begin
      count     <= count - 8'h01;
      nvm_rdata <= ~nvm_rdata;
    end
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb_top
  import dhrs_pkg::*;
;
  localparam int LDL = 200;
  localparam int BLL = 400;
  localparam int CMW = 200;
  localparam int SLW = 400;
  localparam int FLT = 100;

  logic                      clock;
  logic                      srst;
  logic                      hw_reset_n;
  logic                      sleep_out_mode;
  logic [7:0]                delay;
  logic                      nvm_rvalid;
  logic [7:0]                nvm_rdata;
  dhrs_nvm_req_type          nvm_req;
  dhrs_status_type           status;
  logic [NVM_WORDS-1:0][7:0] settings;
  int                        mismatches = 0;
  int                        n_tests = 0;
  int                        cyc = 0;

  dhrs_reset_seq #(.LOAD_LIMIT(LDL), .BLANK_LIMIT(BLL), .CMD_WAIT(CMW), .SLEEP_WAIT(SLW)) dhrs_reset_seq_inst (
    .clock(clock), .srst(srst), .hw_reset_n(hw_reset_n), .sleep_out_mode(sleep_out_mode),
    .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata), .nvm_req(nvm_req), .status(status), .settings(settings));

  dhrs_nvm_model dhrs_nvm_model_inst (
    .clock(clock), .srst(srst), .nvm_req(nvm_req), .delay(delay), .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata));

  // =====================================================
  // clock, timeout and verdict
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ceiling well above the five sequences of under eight hundred cycles each
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // =====================================================
  // helpers
  task automatic at_cycle(input int t);
    while (cyc < t) @(posedge clock);
    #1;
  endtask

  task automatic pin(input logic v, input int n);
    @(posedge clock);
    hw_reset_n <= v;
    repeat (n) @(posedge clock);
    #1;
  endtask

  // =====================================================
  // scenarios
  task automatic test_spike();
    // 99 cycles low, one short of the accept count
    pin(1'b0, 98);
    pin(1'b1, 10);
    `CHK("spike ignored", 1'b0, status.hw_reset_active)
    `CHK("spike no blank", 1'b0, status.display_blank)
  endtask

  task automatic test_reset(input logic sleep, input logic [7:0] dly, input int low_len, input logic glitch);
    int t0;
    int t1;
    @(posedge clock);
    sleep_out_mode <= sleep;
    delay          <= dly;
    t0 = cyc + 2;
    pin(1'b0, 120);
    `CHK("reset active", 1'b1, status.hw_reset_active)
    `CHK("blank in reset", 1'b1, status.display_blank)
    `CHK("settings cleared", 8'h00, settings[CVOLT_INDEX])
    if (glitch) begin
      // 99 cycles high, one short of a release
      pin(1'b1, 98);
      pin(1'b0, 10);
      `CHK("glitch kept reset", 1'b1, status.hw_reset_active)
    end
    at_cycle(t0 + low_len);
    t1 = cyc + 1;
    pin(1'b1, FLT + 5);
    while (status.loading === 1'b1 && cyc < t1 + FLT + LDL) @(posedge clock);
    #1;
    `CHK("reload done", 1'b0, status.loading)
    for (int k = 0; k < NVM_WORDS; k++) begin
      `CHK("settings word", 8'hA0 ^ k[7:0], settings[k])
    end
    repeat (3) @(posedge clock);
    #1;
    `CHK("blank after load", sleep, status.display_blank)
    if (sleep) begin
      at_cycle(t0 + FLT + BLL - 10);
      `CHK("blanking runs", 1'b1, status.display_blank)
      at_cycle(t0 + FLT + BLL + 10);
      `CHK("blanking ends", 1'b0, status.display_blank)
    end
    at_cycle(t1 + FLT + CMW - 5);
    `CHK("command too early", 1'b0, status.cmd_ok)
    at_cycle(t1 + FLT + CMW + 5);
    `CHK("command allowed", 1'b1, status.cmd_ok)
    at_cycle(t1 + FLT + SLW - 5);
    `CHK("sleep exit too early", 1'b0, status.sleep_exit_ok)
    at_cycle(t1 + FLT + SLW + 5);
    `CHK("sleep exit allowed", 1'b1, status.sleep_exit_ok)
  endtask

  // slow memory: reset again mid-reload, then let the reload run out of time
  task automatic test_abandon();
    @(posedge clock);
    sleep_out_mode <= 1'b0;
    delay          <= 8'hFF;
    pin(1'b0, 120);
    pin(1'b1, FLT + 5);
    `CHK("reload running", 1'b1, status.loading)
    pin(1'b0, 120);
    `CHK("reset during reload", 1'b1, status.hw_reset_active)
    `CHK("reload stopped", 1'b0, status.loading)
    pin(1'b1, FLT + LDL + 100);
    `CHK("reload abandoned", 1'b0, status.loading)
    `CHK("blank ends after abandon", 1'b0, status.display_blank)
    for (int k = 0; k < NVM_WORDS; k++) begin
      `CHK("settings unloaded", 8'h00, settings[k])
    end
  endtask

  // =====================================================
  // main sequence
  initial begin
    srst           = 1'b1;
    hw_reset_n     = 1'b1;
    sleep_out_mode = 1'b0;
    delay          = 8'h03;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    pin(1'b1, 5);
    test_spike();
    // mid-band pulse, taken as a reset by this design
    test_reset(1'b0, 8'h03, 150, 1'b0);
    // host holds the pin low past the valid width
    test_reset(1'b0, 8'h14, 250, 1'b1);
    test_reset(1'b1, 8'h03, 250, 1'b0);
    test_abandon();
    complete_run();
  end
endmodule
